// File: verilog/tdh_pkg.sv
// Purpose: Shared constants and types for the tone decoder host port.
// Assumes: One system clock; serial pins arrive asynchronously.
// Notes:   Command codes, register field positions and reset values are collected here.
package tdh_pkg;

  // ----------------------------------------------------------------
  // List geometry
  // ----------------------------------------------------------------
  localparam int TONES   = 32;
  localparam int LISTS   = 2;
  localparam int IDX_W   = 5;
  localparam int CNT_W   = 6;
  localparam int FREQ_W  = 16;
  localparam int GRP_W   = 2;
  localparam int FREQ_MIN_HZ = 280;
  localparam int FREQ_MAX_HZ = 3500;
  localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;

  // ----------------------------------------------------------------
  // Address/command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RESET     = 8'h01;
  localparam logic [7:0] CMD_CONTROL   = 8'h30;
  localparam logic [7:0] CMD_GENERAL   = 8'h33;
  localparam logic [7:0] CMD_TONE_WR   = 8'h34;
  localparam logic [7:0] CMD_STATUS_RD = 8'h38;
  localparam logic [7:0] CMD_RESULT_RD = 8'h39;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTL_RAM_SEL_BIT = 7;
  localparam int CTL_OPM_LSB     = 0;
  localparam logic [1:0] OPM_CLEAR = 2'h3;
  localparam int GEN_G1_BIT      = 7;
  localparam int GEN_G2_BIT      = 6;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] GEN_RESET = 8'h00;
  localparam logic [1:0] TONE_WR_LAST = 2'h2;
  localparam logic [2:0] BIT_LAST  = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_REPLY, PH_IDLE} tdh_phase_t;
  typedef enum logic {SC_IDLE, SC_RUN} tdh_scan_t;

  typedef struct packed {
    logic [GRP_W-1:0]  grp;   // bit0 group one, bit1 group two
    logic [FREQ_W-1:0] freq;
  } tdh_entry_t;

  typedef struct packed {
    logic              valid;
    logic              present;
    logic [FREQ_W-1:0] freq;
  } tdh_meas_t;

  typedef struct packed {
    logic              decoded;
    logic [GRP_W-1:0]  grp;
    logic [IDX_W-1:0]  idx;
  } tdh_result_t;

  typedef struct packed {
    logic             en;
    logic             list;
    logic [IDX_W-1:0] idx;
    tdh_entry_t       entry;
  } tdh_wr_t;

  typedef struct packed {
    tdh_entry_t [LISTS-1:0][TONES-1:0] mem;
  } tdh_ram_t;

endpackage : tdh_pkg

// File: verilog/tdh_tone_ram.sv
// Purpose: Two independent tone lists held in flip-flops.
// Assumes: Writes come from the host port, one entry per cycle.
// Notes:   Read is combinational from the flops; contents survive soft reset.
`timescale 1ns/1ps
module tdh_tone_ram (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire tdh_pkg::tdh_wr_t      wr,
  input  wire logic                  rd_list,
  input  wire logic [4:0]            rd_idx,
  output tdh_pkg::tdh_entry_t        rd_entry
);

  tdh_pkg::tdh_ram_t s_reg;
  tdh_pkg::tdh_ram_t s_next;

  always_comb begin
    s_next = s_reg;
    if (wr.en) begin
      s_next.mem[wr.list][wr.idx] = wr.entry;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_entry = s_reg.mem[rd_list][rd_idx];

  a_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr.en |=> s_reg.mem[$past(wr.list)][$past(wr.idx)] == $past(wr.entry))
    else $error("tone entry not stored in chosen list");

endmodule : tdh_tone_ram

// File: verilog/tdh_host_port.sv
// Purpose: Device side of the four-wire serial host port of a tone decoder.
// Assumes: Serial pins are asynchronous; decode engine shares clk_sys.
// Notes:   Serial clock must be well below clk_sys/4 for edge sampling.
`timescale 1ns/1ps

// Summary of operation
// - Command bytes shift in eight bits, most significant first.
// - Reply bytes shift out on serial clock only while select is low.
// - Reply output is high impedance unless a reply bit is being sent.
// - Select high ends or aborts a sequence; select low starts one.
// - Pending interrupt is shown by pulling the interrupt line low.
// - Interrupt line is open drain: pull low or release.
// - Every change of decode state raises an interrupt.
// - Status and result replies give decode state, tone index and group.
// - Each list stores up to thirty-two tones, filled in arrival order.
// - Two independent lists; control bit picks the active one.
// - Each entry carries membership in group one, two or both.
// - Only entries of the enabled group can match.
// - General bits seven and six enable group one and group two.
module tdh_host_port (
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic                serial_clk,
  input  wire logic                cmd_data,
  input  wire logic                bus_select_low,
  output logic                     reply_data_o,
  output logic                     reply_data_oe_b,
  output logic                     host_interrupt_low_o,
  output logic                     host_interrupt_low_oe_b,
  input  wire tdh_pkg::tdh_meas_t  meas,
  output logic                     active_list,
  output logic                     fast_slow
);

  typedef struct packed {
    logic                                  sclk_s1;
    logic                                  sclk_s2;
    logic                                  sclk_s3;
    logic                                  sd_s1;
    logic                                  sd_s2;
    logic                                  sel_s1;
    logic                                  sel_s2;
    tdh_pkg::tdh_phase_t                   phase;
    logic [2:0]                            bitcnt;
    logic [7:0]                            shin;
    logic [7:0]                            cmd;
    logic [1:0]                            bytecnt;
    logic [1:0]                            grp_hold;
    logic [7:0]                            fhi;
    logic [7:0]                            rsh;
    logic [7:0]                            control;
    logic [7:0]                            general;
    logic [tdh_pkg::LISTS-1:0][5:0]        cnt;
    logic                                  full;
    tdh_pkg::tdh_wr_t                      wr;
    tdh_pkg::tdh_scan_t                    scan;
    logic [4:0]                            scan_idx;
    logic [15:0]                           mfreq;
    tdh_pkg::tdh_result_t                  result;
    logic                                  int_pending;
  } tdh_state_t;

  tdh_state_t           s_reg;
  tdh_state_t           s_next;
  tdh_pkg::tdh_entry_t  rd_entry;
  logic                 rise;
  logic                 elig;
  logic                 fin;
  logic                 status_rd;
  tdh_pkg::tdh_result_t fres;
  logic [7:0]           nb;
  logic                 lsel;

  // ----------------------------------------------------------------
  // Tone lists
  // ----------------------------------------------------------------
  tdh_tone_ram tdh_tone_ram_inst (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .wr       (s_reg.wr),
    .rd_list  (s_reg.control[tdh_pkg::CTL_RAM_SEL_BIT]),
    .rd_idx   (s_reg.scan_idx),
    .rd_entry (rd_entry)
  );

  assign rise = s_reg.sclk_s2 & ~s_reg.sclk_s3;
  assign lsel = s_reg.control[tdh_pkg::CTL_RAM_SEL_BIT];
  // Group gate from the general register group enable bits
  assign elig = (s_reg.general[tdh_pkg::GEN_G1_BIT] & rd_entry.grp[0]) |
                (s_reg.general[tdh_pkg::GEN_G2_BIT] & rd_entry.grp[1]);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next    = s_reg;
    fin       = 1'b0;
    status_rd = 1'b0;
    fres      = '0;
    nb        = {s_reg.shin[6:0], s_reg.sd_s2};
    s_next.sclk_s1 = serial_clk;
    s_next.sclk_s2 = s_reg.sclk_s1;
    s_next.sclk_s3 = s_reg.sclk_s2;
    s_next.sd_s1   = cmd_data;
    s_next.sd_s2   = s_reg.sd_s1;
    s_next.sel_s1  = bus_select_low;
    s_next.sel_s2  = s_reg.sel_s1;
    s_next.wr.en   = 1'b0;

    if (s_reg.sel_s2) begin
      // Select high: finish or abort, next low starts clean
      s_next.phase   = tdh_pkg::PH_CMD;
      s_next.bitcnt  = 3'h0;
      s_next.bytecnt = 2'h0;
    end else if (rise) begin
      s_next.shin   = nb;
      s_next.bitcnt = s_reg.bitcnt + 3'h1;
      if (s_reg.phase == tdh_pkg::PH_REPLY) begin
        s_next.rsh = {s_reg.rsh[6:0], 1'b0};
      end
      if (s_reg.bitcnt == tdh_pkg::BIT_LAST) begin
        case (s_reg.phase)
          tdh_pkg::PH_CMD: begin
            s_next.cmd   = nb;
            s_next.phase = tdh_pkg::PH_DATA;
            case (nb)
              tdh_pkg::CMD_RESET: begin
                // Lists and counts are kept; write registers and the full flag clear
                s_next.control = tdh_pkg::CTL_RESET;
                s_next.general = tdh_pkg::GEN_RESET;
                s_next.full    = 1'b0;
                s_next.phase   = tdh_pkg::PH_IDLE;
              end
              tdh_pkg::CMD_CONTROL, tdh_pkg::CMD_GENERAL, tdh_pkg::CMD_TONE_WR: begin
                s_next.phase = tdh_pkg::PH_DATA;
              end
              tdh_pkg::CMD_STATUS_RD: begin
                s_next.rsh   = {s_reg.result.decoded, s_reg.full, s_reg.cnt[lsel]};
                s_next.phase = tdh_pkg::PH_REPLY;
                status_rd    = 1'b1;
              end
              tdh_pkg::CMD_RESULT_RD: begin
                s_next.rsh   = {s_reg.result.grp, 1'b0, s_reg.result.idx};
                s_next.phase = tdh_pkg::PH_REPLY;
              end
              default: begin
                s_next.phase = tdh_pkg::PH_IDLE;
              end
            endcase
          end
          tdh_pkg::PH_DATA: begin
            case (s_reg.cmd)
              tdh_pkg::CMD_CONTROL: begin
                s_next.control = nb;
                s_next.phase   = tdh_pkg::PH_IDLE;
                if (nb[tdh_pkg::CTL_OPM_LSB +: 2] == tdh_pkg::OPM_CLEAR) begin
                  s_next.cnt[nb[tdh_pkg::CTL_RAM_SEL_BIT]] = 6'h00;
                  s_next.full = 1'b0;
                end
              end
              tdh_pkg::CMD_GENERAL: begin
                s_next.general = nb;
                s_next.phase   = tdh_pkg::PH_IDLE;
              end
              tdh_pkg::CMD_TONE_WR: begin
                // Entries stream in threes: group, freq high, freq low
                s_next.bytecnt = s_reg.bytecnt + 2'h1;
                if (s_reg.bytecnt == 2'h0) begin
                  s_next.grp_hold = nb[1:0];
                end else if (s_reg.bytecnt == 2'h1) begin
                  s_next.fhi = nb;
                end else begin
                  s_next.bytecnt = 2'h0;
                  if (s_reg.cnt[lsel] < tdh_pkg::CNT_FULL) begin
                    s_next.wr.en    = 1'b1;
                    s_next.wr.list  = lsel;
                    s_next.wr.idx   = s_reg.cnt[lsel][4:0];
                    s_next.wr.entry = {s_reg.grp_hold, s_reg.fhi, nb};
                    s_next.cnt[lsel] = s_reg.cnt[lsel] + 6'h01;
                    s_next.full     = (s_reg.cnt[lsel] + 6'h01) == tdh_pkg::CNT_FULL;
                  end
                end
              end
              default: begin
                s_next.phase = tdh_pkg::PH_IDLE;
              end
            endcase
          end
          tdh_pkg::PH_REPLY: begin
            s_next.phase = tdh_pkg::PH_IDLE;
          end
          default: begin
            s_next.phase = tdh_pkg::PH_IDLE;
          end
        endcase
      end
    end

    // Sequential list scan; new measurements are ignored until it ends
    case (s_reg.scan)
      tdh_pkg::SC_IDLE: begin
        if (meas.valid) begin
          if (meas.present) begin
            s_next.scan     = tdh_pkg::SC_RUN;
            s_next.scan_idx = 5'h00;
            s_next.mfreq    = meas.freq;
          end else begin
            fin = 1'b1;
          end
        end
      end
      tdh_pkg::SC_RUN: begin
        if ({1'b0, s_reg.scan_idx} >= s_reg.cnt[lsel]) begin
          fin         = 1'b1;
          s_next.scan = tdh_pkg::SC_IDLE;
        end else if (elig && rd_entry.freq == s_reg.mfreq) begin
          fin          = 1'b1;
          fres.decoded = 1'b1;
          fres.grp     = rd_entry.grp;
          fres.idx     = s_reg.scan_idx;
          s_next.scan  = tdh_pkg::SC_IDLE;
        end else if (s_reg.scan_idx == 5'h1F) begin
          fin         = 1'b1;
          s_next.scan = tdh_pkg::SC_IDLE;
        end else begin
          s_next.scan_idx = s_reg.scan_idx + 5'h01;
        end
      end
      default: begin
        s_next.scan = tdh_pkg::SC_IDLE;
      end
    endcase

    // Clear by status read first so a same-cycle change still sets
    if (status_rd) begin
      s_next.int_pending = 1'b0;
    end
    if (fin) begin
      s_next.result = fres;
      if (fres != s_reg.result) begin
        s_next.int_pending = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_reg         <= '0;
      s_reg.sclk_s1 <= 1'b1;
      s_reg.sclk_s2 <= 1'b1;
      s_reg.sclk_s3 <= 1'b1;
      s_reg.sel_s1  <= 1'b1;
      s_reg.sel_s2  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign reply_data_o    = s_reg.rsh[7];
  assign reply_data_oe_b = ~((s_reg.phase == tdh_pkg::PH_REPLY) & ~s_reg.sel_s2);
  assign host_interrupt_low_o    = 1'b0;
  assign host_interrupt_low_oe_b = ~s_reg.int_pending;
  assign active_list = lsel;
  assign fast_slow   = s_reg.control[6];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_shift_in_msb: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (rise && !s_reg.sel_s2) |=> s_reg.shin == {$past(s_reg.shin[6:0]), $past(s_reg.sd_s2)})
    else $error("command bit not shifted in msb first");

  a_hold_no_edge: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!rise && s_reg.scan == tdh_pkg::SC_IDLE) |=> $stable(s_reg.shin) && $stable(s_reg.rsh))
    else $error("serial shifter moved without a clock edge");

  a_reply_shift: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (rise && !s_reg.sel_s2 && s_reg.phase == tdh_pkg::PH_REPLY)
      |=> reply_data_o == $past(s_reg.rsh[6]))
    else $error("reply bit did not advance on clock");

  a_reply_hiz: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (s_reg.phase != tdh_pkg::PH_REPLY || s_reg.sel_s2) |-> reply_data_oe_b)
    else $error("reply driven outside a reply");

  a_select_abort: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_reg.sel_s2 |=> s_reg.phase == tdh_pkg::PH_CMD && s_reg.bitcnt == 3'h0)
    else $error("select high did not restart sequence");

  a_int_on_change: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (fin && fres != s_reg.result) |=> !host_interrupt_low_oe_b && !host_interrupt_low_o)
    else $error("decode change raised no interrupt");

  a_int_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (status_rd && !fin) |=> host_interrupt_low_oe_b)
    else $error("status read did not release interrupt");

  a_int_holds: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (s_reg.int_pending && !status_rd) |=> s_reg.int_pending)
    else $error("interrupt dropped before status read");

  a_group_match: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (fin && fres.decoded) |-> elig ##1 s_reg.result.decoded)
    else $error("tone matched outside enabled group");

  a_list_fill: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_reg.wr.en |-> s_reg.cnt[s_reg.wr.list] == {1'b0, s_reg.wr.idx} + 6'h01)
    else $error("list write out of fill order");

endmodule : tdh_host_port

// File: sim/tdh_host_model.sv
// Purpose: Host controller model on the four-wire serial control port.
// Assumes: Half period of four clk_sys cycles; idle serial clock high.
// Notes:   Reply is sampled just before each rising edge, as the device shifts after it.
`timescale 1ns/1ps
module tdh_host_model (
  input  wire logic clk_sys,
  output logic      serial_clk,
  output logic      cmd_data,
  output logic      bus_select_low,
  input  wire logic reply_data_o,
  input  wire logic reply_data_oe_b
);
  localparam int HALF = 4;
  logic last_reply;

  initial begin
    serial_clk     = 1'b1;
    cmd_data       = 1'b0;
    bus_select_low = 1'b1;
    last_reply     = 1'b0;
  end

  task automatic half_wait();
    repeat (HALF) @(posedge clk_sys);
    #1;
  endtask : half_wait

  // --------------------------------------------------------------
  // One serial bit: data on the fall, sampled on the rise
  // --------------------------------------------------------------
  task automatic bit_cycle(input logic b, output logic seen);
    serial_clk = 1'b0;
    cmd_data   = b;
    half_wait();
    // Released line is not trusted to hold the last value
    seen       = reply_data_oe_b ? ~last_reply : reply_data_o;
    last_reply = seen;
    serial_clk = 1'b1;
    half_wait();
  endtask : bit_cycle

  // n_cmd below the full byte count aborts the frame on purpose
  task automatic xfer(input logic [7:0] q[$], input int n_cmd, input int n_reply,
                      output logic [7:0] rep);
    logic s;
    rep            = 8'h00;
    bus_select_low = 1'b0;
    half_wait();
    for (int i = 0; i < n_cmd; i++) bit_cycle(q[i / 8][7 - i % 8], s);
    for (int b = 7; b >= 8 - n_reply; b--) begin
      bit_cycle(~cmd_data, s);
      rep[b] = s;
    end
    half_wait();
    bus_select_low = 1'b1;
    cmd_data       = ~cmd_data;
    repeat (2) half_wait();
  endtask : xfer
endmodule : tdh_host_model

// File: sim/tdh_host_port_tb_top.sv
// Purpose: Self-checking bench for the tone decoder host port.
// Assumes: Decode engine is stood in for by bench-driven measurement pulses.
// Notes:   Interrupt wire carries a pull-up; result only compared while decoded.
`timescale 1ns/1ps
module tdh_host_port_tb_top;
  logic               clk_sys = 1'b0;
  logic               rst_b;
  logic               serial_clk, cmd_data, bus_select_low;
  logic               reply_data_o, reply_data_oe_b;
  logic               host_interrupt_low_o, host_interrupt_low_oe_b;
  logic               active_list, fast_slow, irq_wire;
  tdh_pkg::tdh_meas_t meas;
  int                 n_fail, samples_checked, prev, exp_i, k;
  logic [15:0]        tone_freq [32];
  logic [1:0]         tone_grp [32];
  logic [15:0]        f_t;
  logic [1:0]         g_t;
  logic [7:0]         rep, gen;
  logic [7:0]         q [$];
  logic [7:0]         gens [4] = '{8'h80, 8'h40, 8'hC0, 8'h00};
  logic               pres;

  always #25 clk_sys = ~clk_sys;
  assign irq_wire = host_interrupt_low_oe_b ? 1'b1 : host_interrupt_low_o;

  tdh_host_port tdh_host_port_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .serial_clk(serial_clk), .cmd_data(cmd_data),
    .bus_select_low(bus_select_low), .reply_data_o(reply_data_o),
    .reply_data_oe_b(reply_data_oe_b), .host_interrupt_low_o(host_interrupt_low_o),
    .host_interrupt_low_oe_b(host_interrupt_low_oe_b), .meas(meas),
    .active_list(active_list), .fast_slow(fast_slow));

  tdh_host_model tdh_host_model_inst (
    .clk_sys(clk_sys), .serial_clk(serial_clk), .cmd_data(cmd_data),
    .bus_select_low(bus_select_low), .reply_data_o(reply_data_o),
    .reply_data_oe_b(reply_data_oe_b));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] b[$]);
    logic [7:0] r;
    tdh_host_model_inst.xfer(b, b.size() * 8, 0, r);
    check("reply_oe_b_idle", {7'h00, reply_data_oe_b}, 8'h01);
  endtask : wr

  task automatic rd(input logic [7:0] cmd, output logic [7:0] r);
    tdh_host_model_inst.xfer({cmd}, 8, 8, r);
  endtask : rd

  // Scan lasts at most 33 cycles plus the interrupt cycle
  task automatic measure(input logic p, input logic [15:0] f);
    @(posedge clk_sys);
    #1 meas = '{valid: 1'b1, present: p, freq: f};
    @(posedge clk_sys);
    #1 meas.valid = 1'b0;
    repeat (40) @(posedge clk_sys);
    #1;
  endtask : measure

  function automatic int exp_match(input logic [15:0] f, input logic [7:0] g);
    for (int i = 0; i < 32; i++)
      if (tone_freq[i] == f && ((tone_grp[i][0] && g[7]) || (tone_grp[i][1] && g[6])))
        return i;
    return -1;
  endfunction : exp_match

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    stop_test();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    meas = '0;
    n_fail = 0;
    samples_checked = 0;
    void'($urandom(32'h3c10f912));
    repeat (10) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    check("reply_oe_b_rst", {7'h00, reply_data_oe_b}, 8'h01);
    check("irq_rst", {7'h00, irq_wire}, 8'h01);
    rd(tdh_pkg::CMD_STATUS_RD, rep);
    check("status_rst", rep, 8'h00);
    $display("test reset done");

    wr({tdh_pkg::CMD_CONTROL, 8'hC3});
    check("ctl_bits", {6'h00, active_list, fast_slow}, 8'h03);
    wr({tdh_pkg::CMD_CONTROL, 8'h03});
    wr({tdh_pkg::CMD_CONTROL, 8'h00});
    q = {tdh_pkg::CMD_TONE_WR};
    for (int i = 0; i < 33; i++) begin
      f_t = 16'(280 + i * 97 + $urandom_range(40));
      g_t = 2'($urandom_range(3, 1));
      // Entry 33 overflows the list, so it must not touch the model
      if (i < 32) begin
        tone_freq[i] = f_t;
        tone_grp[i]  = g_t;
      end
      q.push_back({6'h00, g_t});
      q.push_back(f_t[15:8]);
      q.push_back(f_t[7:0]);
    end
    wr(q);
    rd(tdh_pkg::CMD_STATUS_RD, rep);
    check("status_full", rep, 8'h60);
    $display("test fill done");

    prev = -1;
    for (int t = 0; t < 24; t++) begin
      if (t % 6 == 0) wr({tdh_pkg::CMD_GENERAL, gens[t / 6]});
      gen   = gens[t / 6];
      k     = $urandom_range(31);
      pres  = ($urandom_range(3) != 0);
      exp_i = pres ? exp_match(tone_freq[k], gen) : -1;
      measure(pres, tone_freq[k]);
      if (exp_i != prev) check("irq_set", {7'h00, irq_wire}, 8'h00);
      else check("irq_quiet", {7'h00, irq_wire}, 8'h01);
      rd(tdh_pkg::CMD_STATUS_RD, rep);
      check("status", rep, {exp_i >= 0, 1'b1, 6'h20});
      check("irq_clr", {7'h00, irq_wire}, 8'h01);
      if (exp_i >= 0) begin
        rd(tdh_pkg::CMD_RESULT_RD, rep);
        check("result", rep, {tone_grp[exp_i], 1'b0, 5'(exp_i)});
      end
      prev = exp_i;
    end
    $display("test decode done");

    wr({tdh_pkg::CMD_CONTROL, 8'h80});
    check("list_sel", {7'h00, active_list}, 8'h01);
    wr({tdh_pkg::CMD_TONE_WR, 8'h01, 8'h0D, 8'hAC, 8'h02, 8'h01, 8'h18});
    wr({tdh_pkg::CMD_GENERAL, 8'hC0});
    rd(tdh_pkg::CMD_STATUS_RD, rep);
    check("status_list2", rep, {prev >= 0, 1'b0, 6'h02});
    measure(1'b1, 16'h0DAC);
    rd(tdh_pkg::CMD_RESULT_RD, rep);
    check("result_hi", rep, 8'h40);
    rd(tdh_pkg::CMD_STATUS_RD, rep);
    check("status_hit", rep, 8'h82);
    measure(1'b1, 16'h0118);
    check("irq_change", {7'h00, irq_wire}, 8'h00);
    rd(tdh_pkg::CMD_RESULT_RD, rep);
    check("result_lo", rep, 8'h81);
    $display("test second list done");

    tdh_host_model_inst.xfer({tdh_pkg::CMD_CONTROL, 8'h00}, 12, 0, rep);
    check("abort_keeps", {7'h00, active_list}, 8'h01);
    wr({8'h55, 8'h00});
    check("unknown_cmd", {7'h00, active_list}, 8'h01);
    wr({tdh_pkg::CMD_RESET});
    check("reset_ctl", {6'h00, active_list, fast_slow}, 8'h00);
    rd(tdh_pkg::CMD_STATUS_RD, rep);
    check("status_soft_rst", rep & 8'h7F, 8'h20);
    $display("test abort and soft reset done");
    stop_test();
  end
endmodule : tdh_host_port_tb_top
